/* File: hdl/tec_event_gen.sv */
`timescale 1ns/1ps
module tec_event_gen
   import tec_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   tec_evg_if.gen   evg
);
   logic [EVG_W-1:0] fifo_mem [EVG_DEPTH];
   logic [3:0]       wr_ptr_r;
   logic [3:0]       rd_ptr_r;
   logic [4:0]       count_r;
   logic [EVG_W-1:0] head;
   logic [EVG_W-1:0] cur_r;
   logic [31:0]      ref_r;
   logic [31:0]      target_r;
   logic [3:0]       hz_cnt_r;
   logic             lvl_r;
   logic             oe_r;
   logic             done_r;
   logic             push_ok;
   logic             pop;
   logic             fire;
   logic             head_is_ref;
   logic             head_is_edge;
   tec_eg_state_t    state_r;

   assign head         = fifo_mem[rd_ptr_r];
   assign head_is_ref  = head[CODE_LSB +: 4] == CMD_SET_REF;
   assign head_is_edge = (head[CODE_LSB+2 +: 2] != 2'h0) && (head[CODE_LSB +: 2] != 2'h0);
   assign push_ok      = evg.push && (count_r != EVG_FULL);
   assign pop          = (state_r == EG_IDLE) && (count_r != 5'h00);
   assign fire         = (state_r == EG_WAIT) && ($signed(evg.acc_ns - target_r) >= 0);

   always_ff @(posedge clk_sys) begin
      if (push_ok) begin
         fifo_mem[wr_ptr_r] <= evg.cmd;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_ptr_r <= 4'h0;
         rd_ptr_r <= 4'h0;
         count_r  <= 5'h00;
      end else begin
         if (push_ok) begin
            wr_ptr_r <= wr_ptr_r + 4'h1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 4'h1;
         end
         if (push_ok && !pop) begin
            count_r <= count_r + 5'h01;
         end else if (pop && !push_ok) begin
            count_r <= count_r - 5'h01;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_r  <= EG_IDLE;
         cur_r    <= '0;
         ref_r    <= 32'h0000_0000;
         target_r <= 32'h0000_0000;
      end else begin
         unique case (state_r)
            EG_IDLE: begin
               if (pop && head_is_ref) begin
                  ref_r <= evg.acc_ns;
               end else if (pop && head_is_edge) begin
                  cur_r    <= head;
                  target_r <= ref_r + {16'h0000, head[DATA_LSB +: 16]};
                  state_r  <= EG_WAIT;
               end
            end
            EG_WAIT: begin
               if (fire) begin
                  if (cur_r[CODE_LSB +: 2] != VAR_FIXED) begin
                     ref_r <= target_r;
                  end
                  state_r <= EG_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         lvl_r    <= 1'b0;
         oe_r     <= 1'b0;
         done_r   <= 1'b0;
         hz_cnt_r <= 4'h0;
      end else begin
         done_r <= (fire && cur_r[STAT_BIT]) || (pop && head_is_ref && head[STAT_BIT]);
         if (fire) begin
            unique case (cur_r[CODE_LSB+2 +: 2])
               EDGE_RISE: lvl_r <= 1'b1;
               EDGE_FALL: lvl_r <= 1'b0;
               default:   lvl_r <= ~lvl_r;
            endcase
            oe_r     <= 1'b1;
            hz_cnt_r <= cur_r[DIS_BIT] ? HIZ_DELAY_CYC : 4'h0;
         end else if (hz_cnt_r != 4'h0) begin
            hz_cnt_r <= hz_cnt_r - 4'h1;
            if (hz_cnt_r == 4'h1) begin
               oe_r <= 1'b0;
            end
         end
      end
   end

   assign evg.full  = count_r == EVG_FULL;
   assign evg.count = count_r;
   assign evg.lvl   = lvl_r;
   assign evg.oe    = oe_r;
   assign evg.done  = done_r;

   chk_fifo_full_drop: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (count_r == EVG_FULL) && !pop |=> count_r == EVG_FULL && wr_ptr_r == $past(wr_ptr_r))
      else $error("push into full fifo changed it");
   chk_fifo_push_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
      evg.push && !evg.full && !pop |=> count_r == $past(count_r) + 5'h01)
      else $error("accepted push not counted");
   chk_hiz_after_event: assert property (@(posedge clk_sys) disable iff (sys_rst)
      fire && cur_r[DIS_BIT] |=> oe_r ##1 !oe_r)
      else $error("pin did not release one cycle after event");
   chk_abs_ref_latch: assert property (@(posedge clk_sys) disable iff (sys_rst)
      pop && head_is_ref |=> ref_r == $past(evg.acc_ns) && state_r == EG_IDLE)
      else $error("reference not latched from time");
endmodule : tec_event_gen

/* File: hdl/tec_time_engine_out.sv */
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module tec_time_engine_out
   import tec_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic [7:0]  gpio_in,
   output logic      [7:0]  gpio_out,
   output logic      [7:0]  gpio_oe,
   output logic             time_clock_output,
   output logic      [2:0]  time_clock_edge_phase
);
   logic        [31:0] time_ctrl_reg_three_r;
   logic        [31:0] time_ctrl_reg_two_r;
   logic        [31:0] pin_config_reg_one_r;
   logic        [31:0] pin_config_reg_two_r;
   logic        [31:0] per_frac_r;
   logic        [7:0]  per_int_r;
   logic        [1:0]  time_latched_status_r;
   logic        [31:0] rdata_r;
   logic        [31:0] rd_mux;
   logic        [63:0] acc_r;
   logic               time_wr;
   logic        [39:0] period;
   logic               ext_tracking_mode_on;
   logic        [2:0]  tracking_source_select;
   logic        [7:0]  tracking_prescaler;
   logic        [7:0]  tracking_nominal_period;
   logic        [7:0]  rate_step_limit;
   logic               tracking_clock_input;
   logic               trk_prev_r;
   logic        [7:0]  presc_cnt_r;
   logic               trk_armed_r;
   logic               div_edge;
   logic signed [47:0] base_r;
   logic signed [47:0] base_sum;
   logic signed [47:0] pend_r;
   logic signed [47:0] nom_fx;
   logic signed [47:0] lim_fx;
   logic signed [47:0] adj;
   logic signed [47:0] inc;
   logic        [7:0]  clock_out_divisor;
   logic               clock_out_invert;
   logic signed [47:0] half_fx;
   logic signed [47:0] co_sum;
   logic signed [47:0] co_rem;
   logic signed [47:0] co_acc_r;
   logic               co_toggle;
   logic               co_lvl_r;
   logic               clko_r;
   logic        [2:0]  phase_r;
   logic        [31:0] pin_cfg;
   logic        [7:0]  gpio_out_r;
   logic        [7:0]  gpio_oe_r;

   tec_evg_if evg1_if ();
   tec_evg_if evg2_if ();

   function automatic logic signed [47:0] clamp_mag(input logic signed [47:0] v,
                                                    input logic signed [47:0] l);
      if (v > l) begin
         return l;
      end else if (v < -l) begin
         return -l;
      end
      return v;
   endfunction : clamp_mag

   // Register file
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         time_ctrl_reg_three_r <= CTRL_THREE_RST;
         time_ctrl_reg_two_r   <= CTRL_TWO_RST;
         pin_config_reg_one_r  <= PIN_CFG_RST;
         pin_config_reg_two_r  <= PIN_CFG_RST;
         per_frac_r            <= PER_FRAC_RST;
         per_int_r             <= PER_INT_RST;
      end else if (reg_wr) begin
         unique case (reg_addr)
            ADDR_CTRL_THREE: time_ctrl_reg_three_r <= reg_wdata;
            ADDR_CTRL_TWO:   time_ctrl_reg_two_r   <= reg_wdata;
            ADDR_PIN_ONE:    pin_config_reg_one_r  <= reg_wdata;
            ADDR_PIN_TWO:    pin_config_reg_two_r  <= reg_wdata;
            ADDR_PER_FRAC:   per_frac_r            <= reg_wdata;
            ADDR_PER_INT:    per_int_r             <= reg_wdata[7:0];
            default: ;
         endcase
      end
   end

   // Done flags: write one clears, new event wins
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         time_latched_status_r <= 2'h0;
      end else begin
         time_latched_status_r <= (time_latched_status_r
                                   & ~((reg_wr && reg_addr == ADDR_STATUS) ? reg_wdata[1:0] : 2'h0))
                                  | {evg2_if.done, evg1_if.done};
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (reg_addr)
         ADDR_CTRL_THREE: rd_mux = time_ctrl_reg_three_r;
         ADDR_CTRL_TWO:   rd_mux = time_ctrl_reg_two_r;
         ADDR_PIN_ONE:    rd_mux = pin_config_reg_one_r;
         ADDR_PIN_TWO:    rd_mux = pin_config_reg_two_r;
         ADDR_PER_FRAC:   rd_mux = per_frac_r;
         ADDR_PER_INT:    rd_mux = {24'h00_0000, per_int_r};
         ADDR_TIME_NS:    rd_mux = acc_r[63:32];
         ADDR_STATUS: begin
            rd_mux[1:0]                = time_latched_status_r;
            rd_mux[ST_CNT1_LSB +: 5]   = evg1_if.count;
            rd_mux[ST_CNT2_LSB +: 5]   = evg2_if.count;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_r;

   // Tracking control fields
   assign ext_tracking_mode_on    = time_ctrl_reg_three_r[TRK_ON_BIT];
   assign tracking_source_select  = time_ctrl_reg_three_r[TRK_SRC_LSB +: 3];
   assign tracking_prescaler      = time_ctrl_reg_three_r[TRK_DIV_LSB +: 8];
   assign tracking_nominal_period = time_ctrl_reg_three_r[TRK_PER_LSB +: 8];
   assign rate_step_limit         = time_ctrl_reg_three_r[TRK_LIM_LSB +: 8];
   assign period                  = {per_int_r, per_frac_r};

   // Prescaled edge of the selected pin
   assign tracking_clock_input = gpio_in[tracking_source_select];
   assign div_edge = ext_tracking_mode_on && tracking_clock_input && !trk_prev_r
                     && (presc_cnt_r + 8'h01 >= tracking_prescaler);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         trk_prev_r  <= 1'b0;
         presc_cnt_r <= 8'h00;
      end else begin
         trk_prev_r <= tracking_clock_input;
         if (!ext_tracking_mode_on || div_edge) begin
            presc_cnt_r <= 8'h00;
         end else if (tracking_clock_input && !trk_prev_r) begin
            presc_cnt_r <= presc_cnt_r + 8'h01;
         end
      end
   end

   // Phase error: nominal edge spacing minus period-based time elapsed
   assign nom_fx   = {8'h00, tracking_nominal_period, 32'h0000_0000};
   assign lim_fx   = {8'h00, rate_step_limit, 32'h0000_0000};
   assign base_sum = base_r + {8'h00, period};
   assign adj      = ext_tracking_mode_on ? clamp_mag(pend_r, lim_fx) : 48'sh0;
   assign inc      = {8'h00, period} + adj;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         base_r      <= 48'sh0;
         pend_r      <= 48'sh0;
         trk_armed_r <= 1'b0;
      end else if (!ext_tracking_mode_on) begin
         base_r      <= 48'sh0;
         pend_r      <= 48'sh0;
         trk_armed_r <= 1'b0;
      end else if (div_edge) begin
         base_r      <= 48'sh0;
         trk_armed_r <= 1'b1;
         pend_r      <= trk_armed_r ? pend_r - adj + (nom_fx - base_sum) : pend_r - adj;
      end else begin
         base_r <= base_sum;
         pend_r <= pend_r - adj;
      end
   end

   // Accumulator: only its rate is steered, the clock is untouched
   assign time_wr = reg_wr && (reg_addr == ADDR_TIME_NS);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         acc_r <= 64'h0;
      end else if (time_wr) begin
         acc_r <= {reg_wdata, 32'h0000_0000};
      end else begin
         acc_r <= acc_r + {{16{inc[47]}}, inc};
      end
   end

   // Clock output generator
   assign clock_out_divisor = (time_ctrl_reg_two_r[CO_DIV_LSB +: 8] == 8'h00)
                              ? 8'h01 : time_ctrl_reg_two_r[CO_DIV_LSB +: 8];
   assign clock_out_invert  = time_ctrl_reg_two_r[CO_INV_BIT];
   assign half_fx   = {6'h00, clock_out_divisor, 2'b00, 32'h0000_0000};
   assign co_sum    = co_acc_r + inc;
   assign co_rem    = co_sum - half_fx;
   assign co_toggle = co_sum >= half_fx;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         co_acc_r <= 48'sh0;
         co_lvl_r <= 1'b0;
         phase_r  <= 3'h0;
      end else if (time_wr) begin
         co_acc_r <= 48'sh0;
         co_lvl_r <= 1'b0;
         phase_r  <= 3'h0;
      end else if (co_toggle) begin
         co_acc_r <= (co_rem >= half_fx) ? 48'sh0 : co_rem;
         co_lvl_r <= ~co_lvl_r;
         phase_r  <= 3'h7 - co_rem[34:32];
      end else begin
         co_acc_r <= co_sum;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         clko_r <= 1'b0;
      end else begin
         clko_r <= (time_wr ? 1'b0 : (co_lvl_r ^ co_toggle)) ^ clock_out_invert;
      end
   end

   assign time_clock_output     = clko_r;
   assign time_clock_edge_phase = phase_r;

   // Event generators
   assign evg1_if.push   = reg_wr && (reg_addr == ADDR_EVG1_CMD);
   assign evg1_if.cmd    = reg_wdata[EVG_W-1:0];
   assign evg1_if.acc_ns = acc_r[63:32];
   assign evg2_if.push   = reg_wr && (reg_addr == ADDR_EVG2_CMD);
   assign evg2_if.cmd    = reg_wdata[EVG_W-1:0];
   assign evg2_if.acc_ns = acc_r[63:32];

   tec_event_gen u_evg1 (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .evg     (evg1_if)
   );

   tec_event_gen u_evg2 (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .evg     (evg2_if)
   );

   // Pin routing, four bits per pin
   assign pin_cfg = {pin_config_reg_two_r[15:0], pin_config_reg_one_r[15:0]};

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         gpio_out_r <= 8'h00;
         gpio_oe_r  <= 8'h00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            unique case (pin_cfg[i*4 +: 4])
               PIN_SRC_CLKO: begin
                  gpio_out_r[i] <= clko_r;
                  gpio_oe_r[i]  <= 1'b1;
               end
               PIN_SRC_EVG1: begin
                  gpio_out_r[i] <= evg1_if.lvl;
                  gpio_oe_r[i]  <= evg1_if.oe;
               end
               PIN_SRC_EVG2: begin
                  gpio_out_r[i] <= evg2_if.lvl;
                  gpio_oe_r[i]  <= evg2_if.oe;
               end
               default: begin
                  gpio_out_r[i] <= 1'b0;
                  gpio_oe_r[i]  <= 1'b0;
               end
            endcase
         end
      end
   end

   assign gpio_out = gpio_out_r;
   assign gpio_oe  = gpio_oe_r;

   chk_inc_step_limit: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ext_tracking_mode_on |-> (inc - $signed({8'h00, period}) <= lim_fx)
                            && (inc - $signed({8'h00, period}) >= -lim_fx))
      else $error("increment deviates beyond step limit");
   chk_inc_nominal: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !ext_tracking_mode_on && !time_wr |=> acc_r == $past(acc_r) + {24'h0, $past(period)})
      else $error("accumulator not advancing by period");
   chk_done_latched: assert property (@(posedge clk_sys) disable iff (sys_rst)
      evg1_if.done |=> time_latched_status_r[0] ##1 1'b1)
      else $error("done event lost");
   chk_clkout_invert: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(clock_out_invert) && !co_toggle && !time_wr && $stable(co_lvl_r)
      |=> clko_r != $past(clko_r))
      else $error("invert did not flip clock output");
   chk_time_write_clko: assert property (@(posedge clk_sys) disable iff (sys_rst)
      time_wr |=> co_acc_r == 48'sh0 && !co_lvl_r && clko_r == $past(clock_out_invert))
      else $error("clock output ignored time write");
endmodule : tec_time_engine_out

/* File: include/tec_evg_if.sv */
`timescale 1ns/1ps
interface tec_evg_if;
   logic        push;
   logic [21:0] cmd;
   logic [31:0] acc_ns;
   logic        full;
   logic [4:0]  count;
   logic        lvl;
   logic        oe;
   logic        done;

   modport ctl (output push, output cmd, output acc_ns,
                input full, input count, input lvl, input oe, input done);
   modport gen (input push, input cmd, input acc_ns,
                output full, output count, output lvl, output oe, output done);
endinterface : tec_evg_if

/* File: include/tec_pkg.sv */
package tec_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL_THREE = 8'h00;
   localparam logic [7:0] ADDR_CTRL_TWO   = 8'h04;
   localparam logic [7:0] ADDR_PIN_ONE    = 8'h08;
   localparam logic [7:0] ADDR_PIN_TWO    = 8'h0c;
   localparam logic [7:0] ADDR_PER_FRAC   = 8'h10;
   localparam logic [7:0] ADDR_PER_INT    = 8'h14;
   localparam logic [7:0] ADDR_TIME_NS    = 8'h18;
   localparam logic [7:0] ADDR_STATUS     = 8'h1c;
   localparam logic [7:0] ADDR_EVG1_CMD   = 8'h20;
   localparam logic [7:0] ADDR_EVG2_CMD   = 8'h24;
   // Tracking control field positions
   localparam int TRK_ON_BIT  = 0;
   localparam int TRK_SRC_LSB = 1;
   localparam int TRK_DIV_LSB = 4;
   localparam int TRK_PER_LSB = 12;
   localparam int TRK_LIM_LSB = 20;
   // Clock out control field positions
   localparam int CO_DIV_LSB = 0;
   localparam int CO_INV_BIT = 8;
   // Status field positions
   localparam int ST_CNT1_LSB = 8;
   localparam int ST_CNT2_LSB = 16;
   // Pin source selector codes
   localparam logic [3:0] PIN_SRC_NONE = 4'h0;
   localparam logic [3:0] PIN_SRC_CLKO = 4'h1;
   localparam logic [3:0] PIN_SRC_EVG1 = 4'h2;
   localparam logic [3:0] PIN_SRC_EVG2 = 4'h3;
   // Reset values
   localparam logic [31:0] CTRL_THREE_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_TWO_RST   = 32'h0000_0001;
   localparam logic [31:0] PIN_CFG_RST    = 32'h0000_0000;
   localparam logic [31:0] PER_FRAC_RST   = 32'h0000_0000;
   localparam logic [7:0]  PER_INT_RST    = 8'h08;
   // Event generator command entry
   localparam int         EVG_W       = 22;
   localparam int         EVG_DEPTH   = 16;
   localparam logic [4:0] EVG_FULL    = 5'h10;
   localparam int         DATA_LSB    = 0;
   localparam int         CODE_LSB    = 16;
   localparam int         DIS_BIT     = 20;
   localparam int         STAT_BIT    = 21;
   localparam logic [3:0] CMD_SET_REF = 4'h2;
   localparam logic [1:0] EDGE_RISE   = 2'h1;
   localparam logic [1:0] EDGE_FALL   = 2'h2;
   localparam logic [1:0] VAR_FIXED   = 2'h1;
   // Timing
   localparam int         CLK_PERIOD_NS = 40;
   localparam int         HIZ_DELAY_NS  = 8;
   localparam int         HIZ_CYC_CALC  = (HIZ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] HIZ_DELAY_CYC = (HIZ_CYC_CALC < 1) ? 4'h1 : 4'(HIZ_CYC_CALC);

   typedef enum logic {EG_IDLE, EG_WAIT} tec_eg_state_t;
endpackage : tec_pkg

/* File: verification/tec_pin_partner.sv */
`timescale 1ns/1ps
module tec_pin_partner #(
   parameter int TRK_HALF_NS = 100
) (
   input  wire logic [7:0] gpio_out,
   input  wire logic [7:0] gpio_oe,
   output logic      [7:0] gpio_in
);
   logic trk_clk = 1'b0;
   // Tracking source: whole ns period, well above 8 ns
   always #(TRK_HALF_NS) trk_clk = ~trk_clk;
   // Driven pins read back, released pins see a moving pattern
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         gpio_in[i] = gpio_oe[i] ? gpio_out[i] : trk_clk;
      end
   end
endmodule : tec_pin_partner

/* File: verification/tec_time_engine_out_tb.sv */
`timescale 1ns/1ps
module tec_time_engine_out_tb;
   import tec_pkg::*;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata, rv, t0;
   logic [7:0]  gpio_in, gpio_out, gpio_oe, ca;
   logic        time_clock_output;
   logic [2:0]  time_clock_edge_phase;
   int          fails = 0;
   int          check_count = 0;
   int          q2[$];
   int          n, tg;
   always #20 clk_sys = ~clk_sys;
   tec_time_engine_out i_tec_time_engine_out (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .time_clock_output(time_clock_output), .time_clock_edge_phase(time_clock_edge_phase));
   tec_pin_partner i_tec_pin_partner (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in));
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : summarize
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      d = reg_rdata;
   endtask : rd
   task automatic wait_pin(int b, logic v);
      int k;
      for (k = 0; k < 2000 && gpio_out[b] !== v; k++) @(negedge clk_sys);
      if (k == 2000) begin
         fails++;
         summarize();
      end
   endtask : wait_pin
   // Accumulator advance over 100 cycles
   task automatic rate(int lo, int hi);
      rd(ADDR_TIME_NS, t0);
      repeat (98) @(posedge clk_sys);
      rd(ADDR_TIME_NS, rv);
      chk("advance", (rv - t0 >= lo) && (rv - t0 <= hi), 1'b1);
   endtask : rate
   initial begin
      void'($urandom(32'h9ec39d90));
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rd(ADDR_CTRL_TWO, rv);
      chk("ctrl_two", rv, CTRL_TWO_RST);
      rd(ADDR_PER_INT, rv);
      chk("per_int", rv[7:0], PER_INT_RST);
      rd(8'h40, rv);
      chk("unmapped", rv, 32'h0);
      wr(ADDR_PER_FRAC, 32'h8000_0000);
      rate(849, 851);
      wr(ADDR_PER_FRAC, 32'h0);
      n = 2 * ($urandom % 30 + 1);
      wr(ADDR_CTRL_TWO, n);
      tg = 0;
      repeat (400) begin
         rv[0] = time_clock_output;
         @(negedge clk_sys);
         if (time_clock_output !== rv[0]) tg++;
      end
      chk("clko_toggles", (tg >= 800 / n - 1) && (tg <= 800 / n + 2), 1'b1);
      wr(ADDR_PIN_TWO, 32'h1);
      wr(ADDR_CTRL_TWO, 32'hff);
      wr(ADDR_TIME_NS, 32'h0);
      repeat (3) @(negedge clk_sys);
      chk("clko_after_load", time_clock_output, 1'b0);
      chk("clko_pin", {gpio_oe[4], gpio_out[4]}, {1'b1, time_clock_output});
      wr(ADDR_CTRL_TWO, 32'h1ff);
      repeat (3) @(negedge clk_sys);
      chk("clock_out_invert", time_clock_output, 1'b1);
      // First edge at 1020 ns lands 4 ns into the 1024 ns step
      wait_pin(4, 1'b0);
      chk("clko_phase", time_clock_edge_phase, 3'h3);
      wr(ADDR_PIN_ONE, 32'h32);
      for (int g = 0; g < 2; g++) begin
         ca = g ? ADDR_EVG2_CMD : ADDR_EVG1_CMD;
         wr(ca, 32'h0022_0000);
         repeat (4) @(posedge clk_sys);
         rd(ADDR_STATUS, rv);
         chk("done_set", rv[g], 1'b1);
         wr(ADDR_STATUS, 32'h1 << g);
         rd(ADDR_STATUS, rv);
         chk("done_clr", rv[1:0], 2'b00);
         wr(ca, 32'h0005_0028);
         wait_pin(g, 1'b1);
         chk("rise_oe", gpio_oe[g], 1'b1);
         wr(ca, 32'h0009_0028);
         wait_pin(g, 1'b0);
         wr(ca, 32'h001f_0028);
         wait_pin(g, 1'b1);
         chk("toggle_oe", gpio_oe[g], 1'b1);
         @(negedge clk_sys);
         chk("hiz", gpio_oe[g], 1'b0);
      end
      for (n = 0; n < 18; n++) begin
         wr(ADDR_EVG2_CMD, 32'h0005_ffff);
         if (n > 0 && q2.size() < EVG_DEPTH) q2.push_back(n);
      end
      rd(ADDR_STATUS, rv);
      chk("fifo_count", rv[20:16], q2.size());
      wr(ADDR_CTRL_THREE, 32'h0012_800f);
      repeat (50) @(posedge clk_sys);
      rate(792, 808);
      // Nominal 48 ns against 40 ns seen: steering capped at +1 ns a cycle
      wr(ADDR_CTRL_THREE, 32'h0013_000f);
      repeat (20) @(posedge clk_sys);
      rate(899, 901);
      summarize();
   end
endmodule : tec_time_engine_out_tb
